// *** hdl/iob_pkg.sv ***
// Package for the I/O buffer output channel controller
package iob_pkg;

    localparam logic [6:0] IOB_NOOP_DELETE_CODE = 7'h7F;
    localparam logic [6:0] IOB_PUNCH_ENABLE_CODE = 7'h12;
    localparam logic [6:0] IOB_OUTPUT_DISABLE_CODE = 7'h14;
    localparam logic [6:0] IOB_START_TEXT_CODE = 7'h02;
    localparam logic [6:0] IOB_MEDIA_ENABLE_DEFAULT = 7'h7F;

    localparam int IOB_CHAR_BITS = 7;
    localparam int IOB_LANE_BITS = 8;

    localparam logic [31:0] IOB_ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] IOB_ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] IOB_ADDR_CMD = 32'h0000_0008;
    localparam logic [31:0] IOB_ADDR_OUTBUF = 32'h0000_000C;
    localparam logic [31:0] IOB_ADDR_INPUT = 32'h0000_0010;

    localparam int IOB_CTRL_CH_PUNCH = 0;
    localparam int IOB_CTRL_CH_CARD = 1;
    localparam int IOB_CTRL_CH_KEYBOARD = 2;
    localparam int IOB_CTRL_CH_PARITY = 3;
    localparam int IOB_CTRL_CH_FREE = 4;
    localparam int IOB_CTRL_CH_COMBINED = 5;
    localparam int IOB_CTRL_CR_INHIBIT = 6;

    localparam int IOB_CMD_OPERATE = 0;
    localparam int IOB_CMD_OUTPUT = 1;
    localparam int IOB_CMD_ABORT = 2;
    localparam int IOB_CMD_DEMAND = 3;
    localparam int IOB_CMD_DEV_READY = 4;
    localparam int IOB_CMD_IN_BUSY = 5;
    localparam int IOB_CMD_TABLE_FULL = 6;

    localparam int IOB_ST_BUSY = 0;
    localparam int IOB_ST_BUF_READY = 1;
    localparam int IOB_ST_ENABLED = 2;
    localparam int IOB_ST_ALARM = 3;
    localparam int IOB_ST_ECHO_MODE = 4;
    localparam int IOB_ST_DATA_ENABLED = 5;
    localparam int IOB_ST_PARITY_ERR = 6;
    localparam int IOB_ST_EOR_ECHO = 7;

    localparam logic [1:0] IOB_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] IOB_HRESP_OKAY = 2'h0;

    typedef enum logic [2:0] {
        IOB_PH_IDLE = 3'b001,
        IOB_PH_WRITE = 3'b010,
        IOB_PH_MOVE = 3'b100
    } iob_phase_type;

    typedef struct packed {
        logic [7:0] data;
        logic write_stb;
        logic move_stb;
    } iob_dev_out_type;

    typedef struct packed {
        logic ahb_pend;
        logic ahb_wr;
        logic [31:0] ahb_addr;
        logic [31:0] hrdata;
        logic [6:0] ctrl;
        logic busy;
        logic buf_ready;
        logic enabled;
        logic alarm;
        logic echo_mode;
        logic data_enabled;
        logic parity_err;
        logic demand_irq;
        iob_phase_type phase;
        iob_dev_out_type dev;
        logic data_ready_irq;
        logic buf_ready_irq;
        logic chan_ready_irq;
        logic busy_test;
        logic eor_echo;
        logic [7:0] in_char;
        logic in_valid;
    } iob_state_type;

endpackage

// *** hdl/iob_channel.sv ***
// I/O buffer output channel controller with AHB-Lite register slave
`timescale 1ns/1ps
module iob_channel #(
    parameter logic [6:0] MEDIA_ENABLE_CODE = iob_pkg::IOB_MEDIA_ENABLE_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output iob_pkg::iob_dev_out_type dev_out,
    output logic data_ready_irq,
    output logic buf_ready_irq,
    output logic chan_ready_irq,
    output logic busy_test,
    output logic eor_echo,
    output logic [7:0] echo_char,
    output logic echo_valid
);
    import iob_pkg::*;

    iob_state_type s_ff;
    iob_state_type nxt_s;

    function automatic logic odd_ones(input logic [7:0] v);
        odd_ones = ^v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [6:0] ch;
        logic [7:0] inb;
        logic is_punch;
        logic is_card;
        logic card_dummy;
        ch = hwdata[6:0];
        inb = hwdata[7:0];
        is_punch = s_ff.ctrl[IOB_CTRL_CH_PUNCH];
        is_card = s_ff.ctrl[IOB_CTRL_CH_CARD];
        card_dummy = 1'b0;
        nxt_s = s_ff;
        nxt_s.dev.write_stb = 1'b0;
        nxt_s.dev.move_stb = 1'b0;
        nxt_s.in_valid = 1'b0;
        nxt_s.demand_irq = 1'b0;

        // Address phase capture
        if (hsel && hready && htrans == IOB_HTRANS_NONSEQ) begin
            nxt_s.ahb_pend = 1'b1;
            nxt_s.ahb_wr = hwrite;
            nxt_s.ahb_addr = haddr;
        end else begin
            nxt_s.ahb_pend = 1'b0;
        end

        if (s_ff.ahb_pend && s_ff.ahb_wr) begin
            unique case (s_ff.ahb_addr)
                IOB_ADDR_CTRL: nxt_s.ctrl = hwdata[6:0];
                IOB_ADDR_CMD: begin
                    if (hwdata[8 + IOB_CMD_OPERATE]) begin
                        nxt_s.busy = 1'b1;
                        if (ch == MEDIA_ENABLE_CODE
                            || (is_punch && ch == IOB_PUNCH_ENABLE_CODE)) begin
                            nxt_s.enabled = 1'b1;
                        end
                        if (s_ff.ctrl[IOB_CTRL_CH_KEYBOARD] && ch == IOB_START_TEXT_CODE) begin
                            nxt_s.echo_mode = 1'b1;
                        end
                        if (ch == IOB_NOOP_DELETE_CODE) begin
                            nxt_s.buf_ready = 1'b1;
                        end
                    end
                    if (hwdata[8 + IOB_CMD_ABORT]) begin
                        nxt_s.busy = 1'b0;
                        nxt_s.enabled = 1'b0;
                        nxt_s.alarm = 1'b0;
                        nxt_s.buf_ready = 1'b1;
                        nxt_s.echo_mode = 1'b0;
                        nxt_s.data_enabled = 1'b0;
                        nxt_s.phase = IOB_PH_IDLE;
                    end
                    if (hwdata[8 + IOB_CMD_DEMAND] && !s_ff.busy) begin
                        nxt_s.demand_irq = 1'b1;
                    end
                    if (hwdata[8 + IOB_CMD_OUTPUT] && s_ff.busy && s_ff.enabled) begin
                        if (ch == IOB_NOOP_DELETE_CODE) begin
                            nxt_s.buf_ready = 1'b1;
                        end else begin
                            nxt_s.dev.data = {odd_ones({1'b0, ch}), ch};
                            nxt_s.buf_ready = 1'b0;
                            if (!(ch == IOB_OUTPUT_DISABLE_CODE && is_card)) begin
                                if (!s_ff.ctrl[IOB_CTRL_CH_FREE]) begin
                                    nxt_s.phase = IOB_PH_WRITE;
                                end else begin
                                    card_dummy = 1'b1;
                                end
                            end else begin
                                nxt_s.buf_ready = 1'b1;
                            end
                            if (ch == IOB_OUTPUT_DISABLE_CODE) begin
                                nxt_s.busy = 1'b0;
                                nxt_s.enabled = 1'b0;
                            end
                        end
                    end
                    if (hwdata[8 + IOB_CMD_DEV_READY] && s_ff.phase == IOB_PH_IDLE) begin
                        nxt_s.buf_ready = 1'b1;
                    end
                end
                IOB_ADDR_INPUT: begin
                    nxt_s.parity_err = odd_ones(inb);
                    if (s_ff.ctrl[IOB_CTRL_CH_PARITY] && odd_ones(inb)) begin
                        nxt_s.alarm = 1'b1;
                    end
                    if (is_punch == 1'b0 && !s_ff.data_enabled
                        && inb[6:0] == IOB_START_TEXT_CODE) begin
                        nxt_s.data_enabled = 1'b1;
                    end else begin
                        nxt_s.in_char = {1'b0, inb[6:0]};
                        nxt_s.in_valid = s_ff.echo_mode;
                    end
                end
                default: ;
            endcase
        end

        // Write then move sequencing
        unique case (s_ff.phase)
            IOB_PH_IDLE: ;
            IOB_PH_WRITE: begin
                nxt_s.dev.write_stb = 1'b1;
                nxt_s.phase = IOB_PH_MOVE;
            end
            IOB_PH_MOVE: begin
                nxt_s.dev.move_stb = 1'b1;
                nxt_s.phase = IOB_PH_IDLE;
            end
            default: nxt_s.phase = IOB_PH_IDLE;
        endcase
        if (card_dummy) begin
            nxt_s.dev.write_stb = 1'b1;
        end

        // Level-true interrupt and test lines
        nxt_s.busy_test = nxt_s.busy
            | (s_ff.ctrl[IOB_CTRL_CH_COMBINED] & hwdata[8 + IOB_CMD_IN_BUSY]
               & s_ff.ahb_pend & s_ff.ahb_wr & (s_ff.ahb_addr == IOB_ADDR_CMD));
        nxt_s.buf_ready_irq = nxt_s.buf_ready;
        nxt_s.data_ready_irq = nxt_s.in_valid | nxt_s.data_enabled;
        nxt_s.chan_ready_irq = !s_ff.ctrl[IOB_CTRL_CR_INHIBIT]
            & (nxt_s.busy | nxt_s.demand_irq);
        nxt_s.eor_echo = is_punch
            ? (!nxt_s.busy | (hwdata[8 + IOB_CMD_TABLE_FULL] & s_ff.ahb_pend
               & s_ff.ahb_wr & (s_ff.ahb_addr == IOB_ADDR_CMD)))
            : !nxt_s.chan_ready_irq;

        // Read data
        unique case (haddr)
            IOB_ADDR_CTRL: nxt_s.hrdata = {25'h0, nxt_s.ctrl};
            IOB_ADDR_STATUS: nxt_s.hrdata = {24'h0, nxt_s.eor_echo, nxt_s.parity_err,
                nxt_s.data_enabled, nxt_s.echo_mode, nxt_s.alarm, nxt_s.enabled,
                nxt_s.buf_ready, nxt_s.busy};
            IOB_ADDR_OUTBUF: nxt_s.hrdata = {24'h0, nxt_s.dev.data};
            IOB_ADDR_INPUT: nxt_s.hrdata = {24'h0, nxt_s.in_char};
            default: nxt_s.hrdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
            s_ff.phase <= IOB_PH_IDLE;
            s_ff.buf_ready <= 1'b1;
            s_ff.buf_ready_irq <= 1'b1;
            s_ff.eor_echo <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hrdata = s_ff.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = IOB_HRESP_OKAY[0];
    assign dev_out = s_ff.dev;
    assign data_ready_irq = s_ff.data_ready_irq;
    assign buf_ready_irq = s_ff.buf_ready_irq;
    assign chan_ready_irq = s_ff.chan_ready_irq;
    assign busy_test = s_ff.busy_test;
    assign eor_echo = s_ff.eor_echo;
    assign echo_char = s_ff.in_char;
    assign echo_valid = s_ff.in_valid;

endmodule

// *** verif/iob_channel_chk.sv ***
// Checker for the output channel port behaviour
`timescale 1ns/1ps
module iob_channel_chk
import iob_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic busy_test,
    input wire logic buf_ready_irq,
    input wire logic eor_echo,
    input wire iob_pkg::iob_dev_out_type dev_out
);
    import iob_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////////
    write_then_move_a: assert property (dev_out.write_stb |=> dev_out.move_stb)
        else $error("move did not follow write");
    move_cause_a: assert property (dev_out.move_stb |-> $past(dev_out.write_stb))
        else $error("move without write");
    strobe_single_a: assert property (dev_out.write_stb |=> !dev_out.write_stb)
        else $error("write strobe too long");
    parity_even_a: assert property (dev_out.write_stb |-> !(^dev_out.data))
        else $error("output parity odd");
    buf_clear_a: assert property (dev_out.write_stb |-> !buf_ready_irq)
        else $error("buffer ready set during write");
    write_busy_a: assert property (dev_out.write_stb |-> $past(busy_test, 2))
        else $error("write on idle channel");
    reset_state_a: assert property ($rose(hresetn) |-> buf_ready_irq && !busy_test && eor_echo)
        else $error("bad state after reset");
    buf_fall_a: assert property ($fell(buf_ready_irq) |-> $past(busy_test))
        else $error("buffer ready cleared on idle channel");
    cover property (dev_out.write_stb);
    cover property ($fell(buf_ready_irq));
    cover property ($rose(eor_echo));
endmodule

// *** verif/iob_periph_model.sv ***
// Character peripheral model recording each write
`timescale 1ns/1ps
module iob_periph_model
import iob_pkg::*;
(
    input wire logic hclk,
    input wire iob_pkg::iob_dev_out_type dev_out,
    output int n_wr,
    output logic [7:0] last_data
);
    import iob_pkg::*;
    initial n_wr = 0;
    always @(posedge hclk) begin
        if (dev_out.write_stb) begin
            n_wr <= n_wr + 1;
            last_data <= dev_out.data;
        end
    end
endmodule

// *** verif/iob_channel_tb.sv ***
// Testbench for the output channel controller
`timescale 1ns/1ps
module iob_channel_tb;
    import iob_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv, hrdata;
    logic hreadyout, hresp, dri, bri, cri, bt, eor, ev;
    logic [7:0] ec, last_data;
    logic [6:0] chars [3] = '{7'h12, 7'h41, 7'h30};
    iob_dev_out_type dev_out;
    int err_count = 0, n_compared = 0, cyc = 0, n_echo = 0, n_cr = 0, n_wr;
    iob_channel iob_channel_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dev_out(dev_out), .data_ready_irq(dri), .buf_ready_irq(bri), .chan_ready_irq(cri),
        .busy_test(bt), .eor_echo(eor), .echo_char(ec), .echo_valid(ev));
    iob_periph_model iob_periph_model_inst (.hclk(hclk), .dev_out(dev_out), .n_wr(n_wr),
        .last_data(last_data));
    ////////////////////////////////////////////////////////////////////////////////
    always #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        n_echo += ev;
        n_cr += cri && !bt;
        if (cyc == 20000) begin
            err_count++;
            stop_test;
        end
    end
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= IOB_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic cmd(input logic [31:0] v);
        bus(1'b1, IOB_ADDR_CMD, v);
        repeat (4) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stat(input int b, input logic exp);
        bus(1'b0, IOB_ADDR_STATUS, 32'h0);
        chk({31'h0, rdv[b]}, {31'h0, exp});
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        stat(IOB_ST_BUF_READY, 1'b1);
        stat(IOB_ST_BUSY, 1'b0);
        bus(1'b0, 32'h0000_0020, 32'h0);
        chk(rdv, 32'h0);
        bus(1'b1, IOB_ADDR_CTRL, 32'h0000_0001);
        stat(IOB_ST_BUSY, 1'b0);
        cmd(32'h0000_0112);
        stat(IOB_ST_BUSY, 1'b1);
        chk(n_wr, 0);
        chk(eor, 0);
        foreach (chars[i]) begin
            cmd(32'h0000_0200 | chars[i]);
            chk(last_data, {^chars[i], chars[i]});
            chk(n_wr, i + 1);
            stat(IOB_ST_BUF_READY, 1'b0);
            cmd(32'h0000_1000);
        end
        cmd(32'h0000_027F);
        chk(n_wr, 3);
        stat(IOB_ST_BUF_READY, 1'b1);
        cmd(32'h0000_0214);
        chk(last_data, 8'h14);
        stat(IOB_ST_BUSY, 1'b0);
        chk(eor, 1);
        cmd(32'h0000_0112);
        bus(1'b1, IOB_ADDR_CMD, 32'h0000_4000);
        @(negedge hclk);
        chk(eor, 1);
        repeat (4) @(posedge hclk);
        chk(eor, 0);
        cmd(32'h0000_0400);
        stat(IOB_ST_BUSY, 1'b0);
        bus(1'b1, IOB_ADDR_CTRL, 32'h0000_0002);
        cmd(32'h0000_017F);
        cmd(32'h0000_0214);
        chk(n_wr, 4);
        stat(IOB_ST_BUSY, 1'b0);
        bus(1'b1, IOB_ADDR_CTRL, 32'h0000_0008);
        bus(1'b1, IOB_ADDR_INPUT, 32'h0000_0003);
        stat(IOB_ST_PARITY_ERR, 1'b0);
        bus(1'b1, IOB_ADDR_INPUT, 32'h0000_0001);
        stat(IOB_ST_ALARM, 1'b1);
        bus(1'b1, IOB_ADDR_CTRL, 32'h0000_0004);
        cmd(32'h0000_0102);
        stat(IOB_ST_ECHO_MODE, 1'b1);
        bus(1'b1, IOB_ADDR_INPUT, 32'h0000_0041);
        repeat (3) @(posedge hclk);
        chk(n_echo, 1);
        chk(ec, 8'h41);
        cmd(32'h0000_0400);
        cmd(32'h0000_0800);
        chk(n_cr != 0, 1);
        stop_test;
    end
endmodule
bind iob_channel iob_channel_chk iob_channel_chk_inst (.hclk, .hresetn, .busy_test,
    .buf_ready_irq, .eor_echo, .dev_out);
